// >>> verilog/rsp_regs.vh
// rsp_regs.vh: register map, field positions and fixed codes.
// assumes inclusion by rsp_* design files; no logic.
`ifndef RSP_REGS_VH
`define RSP_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets on the apb bus
`define RSP_OFF_STATUS   8'h00
`define RSP_OFF_FLAGS    8'h04
`define RSP_OFF_RXDATA   8'h08
`define RSP_OFF_TXDATA   8'h0C
`define RSP_OFF_PARAM    8'h10

////////////////////////////////////////////////////////////////////////////////
// status word fields
`define RSP_ST_REMOTE    0
`define RSP_ST_COMMANDED 1
`define RSP_ST_TALKER    2
`define RSP_ST_RXVALID   3
`define RSP_ST_TXPEND    4
`define RSP_ST_MASTER    5
`define RSP_ST_PAREN     6
`define RSP_ST_PAREVEN   7
`define RSP_ST_ADDR_LO   8
`define RSP_ST_RATE_LO   16
`define RSP_ST_LISTENER  20

// sticky error flags, write one to clear
`define RSP_FL_PARITY    0
`define RSP_FL_FRAMING   1
`define RSP_FL_OVERRUN   2

////////////////////////////////////////////////////////////////////////////////
// option switch bank positions
`define RSP_SW_ADDR_HI   4
`define RSP_SW_PARSENSE  5
`define RSP_SW_PAREN     6
`define RSP_SW_MASTER    7

// as-delivered rate code (1200 baud)
`define RSP_RATE_DEFAULT 4'h7

////////////////////////////////////////////////////////////////////////////////
// character framing and message coding
`define RSP_OVS_LAST     4'hF
`define RSP_OVS_MID      4'h7
`define RSP_LAST_BIT     3'h7
`define RSP_CHR_ADDR     7
`define RSP_CHR_TALK     6
`define RSP_CMD_LOCAL    8'h7E
`define RSP_CMD_REMOTE   8'h7D

`endif

// >>> verilog/rsp_fifo.v
// rsp_fifo.v: synchronous fifo for received message characters.
// assumes one clock, a freezing clock enable, async low reset.
`timescale 1ns/10ps
module rsp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_i,
  input  wire             reset_n_i,
  input  wire             ce_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            do_push;
  wire            do_pop;

  ////////////////////////////////////////////////////////////////////////////
  // honest flags straight from the occupancy count
  assign in_ready_o  = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign do_push     = ce_i & in_valid_i & in_ready_o;
  assign do_pop      = ce_i & out_ready_i & out_valid_o;

  // storage has no reset; only the pointers and the count carry control state
  always @(posedge clk_i) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers wrap at depth, so depth need not be a power of two
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop & ~do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// >>> verilog/rsp_baud.v
// rsp_baud.v: sixteen-times oversampling tick generator for the selected rate.
// assumes the rate code is stable apart from its one load after reset.
`timescale 1ns/10ps
module rsp_baud #(
  parameter CLK_HZ = 100000000,
  parameter CW     = 17
) (
  input  wire       clk_i,
  input  wire       reset_n_i,
  input  wire       ce_i,
  input  wire [3:0] rate_i,
  output reg        tick_o
);

  reg  [CW-1:0] cnt_reg;
  wire [CW-1:0] div_w;

  // rate table in tenths of a baud so that 134.5 stays exact
  function [CW-1:0] baud_div;
    input [3:0] code;
    integer     bx10;
    integer     tmp;
    begin
      case (code)
        4'h0:    bx10 = 500;
        4'h1:    bx10 = 750;
        4'h2:    bx10 = 1100;
        4'h3:    bx10 = 1345;
        4'h4:    bx10 = 1500;
        4'h5:    bx10 = 3000;
        4'h6:    bx10 = 6000;
        4'h7:    bx10 = 12000;
        4'h8:    bx10 = 18000;
        4'h9:    bx10 = 20000;
        4'hA:    bx10 = 24000;
        4'hB:    bx10 = 36000;
        4'hC:    bx10 = 48000;
        4'hD:    bx10 = 72000;
        4'hE:    bx10 = 96000;
        default: bx10 = 192000;
      endcase
      tmp = (CLK_HZ / 16) * 10 / bx10; // [RQ2]
      if (tmp < 1) begin
        tmp = 1;
      end
      baud_div = tmp[CW-1:0];
    end
  endfunction

  assign div_w = baud_div(rate_i);

  // free-running divider; rounding error stays below one clock per tick
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= {CW{1'b0}};
      tick_o  <= 1'b0;
    end else if (ce_i) begin
      if (cnt_reg >= div_w - 1'b1) begin
        cnt_reg <= {CW{1'b0}};
        tick_o  <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
        tick_o  <= 1'b0;
      end
    end
  end

endmodule

// >>> verilog/rsp_top.v
// rsp_top.v: switch-configured remote serial port with daisy-chain address filter.
// assumes apb master on CLK_I, switch and button inputs synchronous to CLK_I.
// What this block does
// [RQ1] rate switches: open reads one, closed reads zero.
// [RQ2] rate codes 0..15 select 50 up to 19200 baud in table order.
// [RQ3] rate code 7, 1200 baud, is the delivered default.
// [RQ4] address and option switches: closed reads one, open reads zero.
// [RQ5] five-bit receiver address from positions one to five, values 0 to 31.
// [RQ6] repeat the line downstream; accept data only when own address matches.
// [RQ7] controller uses at most 32 distinct addresses on one chain.
// [RQ8] master switch 0 means slave; 1 means transmit parameter data continuously.
// [RQ9] parity enable switch decides whether each character carries parity.
// [RQ10] parity sense switch: one means even, zero means odd.
// [RQ11] remote button enters remote; else first message after power-on does.
// [RQ12] answer talk addressing whether or not in remote mode.
// [RQ13] remote commands choosing local or remote mode are ignored.
// [RQ14] local or remote state is readable remotely.
// [RQ15] frame: start bit, data lsb first, optional parity, one stop bit.
// [RQ16] switch settings sampled once after reset and used for all traffic.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "rsp_regs.vh"
module rsp_top #(
  parameter CLK_HZ = 100000000,
  parameter DEPTH  = 16
) (
  input  wire        CLK_I,
  input  wire        RESET_N_I,
  input  wire        CE_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output wire        PREADY_O,
  output reg         PSLVERR_O,
  input  wire [3:0]  RATE_SELECT_SWITCHES_I,
  input  wire [7:0]  ADDRESS_OPTION_SWITCHES_I,
  input  wire        REMOTE_BTN_I,
  input  wire        LOCAL_BTN_I,
  input  wire        RXD_I,
  output reg         RPT_TXD_O,
  output reg         TXD_O,
  output wire        REMOTE_MODE_O
);

  localparam ST_IDLE   = 3'h0;
  localparam ST_START  = 3'h1;
  localparam ST_DATA   = 3'h2;
  localparam ST_PARITY = 3'h3;
  localparam ST_STOP   = 3'h4;

  reg  [3:0] rate_reg;
  reg  [4:0] addr_reg;
  reg        master_reg;
  reg        par_en_reg;
  reg        par_even_reg;
  reg        cfg_done_reg;
  reg        remote_reg;
  reg        commanded_reg;
  reg        talker_reg;
  reg        listener_reg;
  reg  [2:0] flags_reg;
  reg  [7:0] param_reg;
  reg  [7:0] txhold_reg;
  reg        txpend_reg;
  reg  [2:0] rx_state_reg;
  reg  [3:0] rx_cnt_reg;
  reg  [2:0] rx_bit_reg;
  reg  [7:0] rx_sh_reg;
  reg        rx_perr_reg;
  reg  [2:0] tx_state_reg;
  reg  [3:0] tx_cnt_reg;
  reg  [2:0] tx_bit_reg;
  reg  [7:0] tx_sh_reg;
  wire       tick;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire       apb_setup;
  wire       apb_wr;
  wire       apb_rd_pop;
  wire       rx_done;
  wire       rx_frame_ok;
  wire       rx_is_addr;
  wire       rx_hit;
  wire       rx_is_mode_cmd;
  wire       rx_accept;
  wire       push_req;
  wire [2:0] flag_set;
  wire [2:0] flag_clr;

  // parity bit that makes the ones count even or odd as selected
  function par_bit;
    input [7:0] data;
    input       even;
    begin
      par_bit = even ? (^data) : ~(^data); // [RQ10]
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // switch capture: one load after reset so a bumped switch cannot upset traffic
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rate_reg     <= `RSP_RATE_DEFAULT; // [RQ3]
      addr_reg     <= 5'h00;
      master_reg   <= 1'b0;
      par_en_reg   <= 1'b0;
      par_even_reg <= 1'b0;
      cfg_done_reg <= 1'b0;
    end else if (CE_I && !cfg_done_reg) begin
      cfg_done_reg <= 1'b1; // [RQ16]
      // pins read high for an open switch on both banks
      rate_reg     <= RATE_SELECT_SWITCHES_I; // [RQ1]
      addr_reg     <= ~ADDRESS_OPTION_SWITCHES_I[`RSP_SW_ADDR_HI:0]; // [RQ4] [RQ5]
      master_reg   <= ~ADDRESS_OPTION_SWITCHES_I[`RSP_SW_MASTER]; // [RQ8]
      par_en_reg   <= ~ADDRESS_OPTION_SWITCHES_I[`RSP_SW_PAREN]; // [RQ9]
      par_even_reg <= ~ADDRESS_OPTION_SWITCHES_I[`RSP_SW_PARSENSE]; // [RQ10]
    end
  end

  rsp_baud #(
    .CLK_HZ (CLK_HZ),
    .CW     (17)
  ) u_baud (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .ce_i      (CE_I),
    .rate_i    (rate_reg),
    .tick_o    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // downstream repeater: one clock of delay, idle line high during reset
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RPT_TXD_O <= 1'b1;
    end else if (CE_I) begin
      RPT_TXD_O <= RXD_I; // [RQ6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver: mid-bit sampling on the eighth tick of each bit
  assign rx_done     = CE_I & tick & (rx_state_reg == ST_STOP) & (rx_cnt_reg == `RSP_OVS_LAST);
  assign rx_frame_ok = RXD_I & ~rx_perr_reg;

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rx_state_reg <= ST_IDLE;
      rx_cnt_reg   <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_sh_reg    <= 8'h00;
      rx_perr_reg  <= 1'b0;
    end else if (CE_I) begin
      case (rx_state_reg)
        ST_IDLE: begin
          rx_cnt_reg  <= 4'h0;
          rx_perr_reg <= 1'b0;
          if (!RXD_I) begin
            rx_state_reg <= ST_START; // [RQ15]
          end
        end
        ST_START: begin
          if (tick) begin
            rx_cnt_reg <= rx_cnt_reg + 1'b1;
            if (rx_cnt_reg == `RSP_OVS_MID) begin
              rx_cnt_reg   <= 4'h0;
              rx_bit_reg   <= 3'h0;
              // a glitch shorter than half a bit is not a start
              rx_state_reg <= RXD_I ? ST_IDLE : ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (tick) begin
            rx_cnt_reg <= rx_cnt_reg + 1'b1;
            if (rx_cnt_reg == `RSP_OVS_LAST) begin
              rx_sh_reg  <= {RXD_I, rx_sh_reg[7:1]}; // [RQ15]
              rx_bit_reg <= rx_bit_reg + 1'b1;
              if (rx_bit_reg == `RSP_LAST_BIT) begin
                rx_state_reg <= par_en_reg ? ST_PARITY : ST_STOP; // [RQ9]
              end
            end
          end
        end
        ST_PARITY: begin
          if (tick) begin
            rx_cnt_reg <= rx_cnt_reg + 1'b1;
            if (rx_cnt_reg == `RSP_OVS_LAST) begin
              rx_perr_reg  <= (RXD_I != par_bit(rx_sh_reg, par_even_reg)); // [RQ9]
              rx_state_reg <= ST_STOP;
            end
          end
        end
        default: begin
          if (tick) begin
            rx_cnt_reg <= rx_cnt_reg + 1'b1;
            if (rx_cnt_reg == `RSP_OVS_LAST) begin
              rx_state_reg <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address filter and message acceptance
  assign rx_is_addr     = rx_sh_reg[`RSP_CHR_ADDR];
  assign rx_hit         = (rx_sh_reg[`RSP_SW_ADDR_HI:0] == addr_reg);
  assign rx_is_mode_cmd = (rx_sh_reg == `RSP_CMD_LOCAL) | (rx_sh_reg == `RSP_CMD_REMOTE);
  // data only as listener; in local mode only the first message counts
  assign rx_accept = rx_done & rx_frame_ok & ~rx_is_addr & listener_reg &
                     (remote_reg | ~commanded_reg); // [RQ6] [RQ11]
  assign push_req  = rx_accept & ~rx_is_mode_cmd; // [RQ13]

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      talker_reg   <= 1'b0;
      listener_reg <= 1'b0;
    end else if (rx_done && rx_frame_ok && rx_is_addr) begin
      // a foreign address deselects this unit from both roles
      talker_reg   <= rx_hit & rx_sh_reg[`RSP_CHR_TALK]; // [RQ12]
      listener_reg <= rx_hit & ~rx_sh_reg[`RSP_CHR_TALK]; // [RQ6]
    end
  end

  // mode: panel buttons always win; a mode command sets remote only when it is the first accepted message
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      remote_reg    <= 1'b0;
      commanded_reg <= 1'b0;
    end else if (CE_I) begin
      if (LOCAL_BTN_I) begin
        remote_reg <= 1'b0;
      end else if (REMOTE_BTN_I) begin
        remote_reg <= 1'b1; // [RQ11]
      end else if (rx_accept && !commanded_reg) begin
        remote_reg <= 1'b1; // [RQ11]
      end
      if (rx_accept) begin
        commanded_reg <= 1'b1;
      end
    end
  end

  assign REMOTE_MODE_O = remote_reg;

  rsp_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (4)
  ) u_fifo (
    .clk_i       (CLK_I),
    .reset_n_i   (RESET_N_I),
    .ce_i        (CE_I),
    .in_data_i   (rx_sh_reg),
    .in_valid_i  (push_req),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (apb_rd_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sticky error flags: a new event outweighs a clear in the same cycle
  assign flag_set = {push_req & ~fifo_in_ready,
                     rx_done & ~RXD_I,
                     rx_done & rx_perr_reg};
  assign flag_clr = (apb_wr && PADDR_I == `RSP_OFF_FLAGS) ? PWDATA_I[2:0] : 3'h0;

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      flags_reg <= 3'h0;
    end else if (CE_I) begin
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: talker sends software bytes, master repeats param
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tx_state_reg <= ST_IDLE;
      tx_cnt_reg   <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_sh_reg    <= 8'h00;
      TXD_O        <= 1'b1;
    end else if (CE_I) begin
      if (tx_state_reg == ST_IDLE) begin
        tx_cnt_reg <= 4'h0;
        tx_bit_reg <= 3'h0;
        if (tick && txpend_reg && (talker_reg || master_reg)) begin
          tx_sh_reg    <= txhold_reg; // [RQ12]
          tx_state_reg <= ST_START;
          TXD_O        <= 1'b0;
        end else if (tick && master_reg) begin
          tx_sh_reg    <= param_reg; // [RQ8]
          tx_state_reg <= ST_START;
          TXD_O        <= 1'b0;
        end
      end else if (tick) begin
        tx_cnt_reg <= tx_cnt_reg + 1'b1;
        if (tx_cnt_reg == `RSP_OVS_LAST) begin
          case (tx_state_reg)
            ST_START: begin
              tx_state_reg <= ST_DATA;
              TXD_O        <= tx_sh_reg[0]; // [RQ15]
            end
            ST_DATA: begin
              tx_bit_reg <= tx_bit_reg + 1'b1;
              if (tx_bit_reg == `RSP_LAST_BIT) begin
                tx_state_reg <= par_en_reg ? ST_PARITY : ST_STOP;
                TXD_O        <= par_en_reg ? par_bit(tx_sh_reg, par_even_reg) : 1'b1;
              end else begin
                TXD_O <= tx_sh_reg[tx_bit_reg + 1'b1];
              end
            end
            ST_PARITY: begin
              tx_state_reg <= ST_STOP;
              TXD_O        <= 1'b1;
            end
            default: begin
              tx_state_reg <= ST_IDLE;
              TXD_O        <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data registered in the setup cycle
  assign PREADY_O   = 1'b1;
  assign apb_setup  = CE_I & PSEL_I & ~PENABLE_I;
  assign apb_wr     = CE_I & PSEL_I & PENABLE_I & PWRITE_I;
  assign apb_rd_pop = CE_I & PSEL_I & PENABLE_I & ~PWRITE_I & (PADDR_I == `RSP_OFF_RXDATA);

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      param_reg  <= 8'h00;
      txhold_reg <= 8'h00;
      txpend_reg <= 1'b0;
    end else if (CE_I) begin
      if (apb_wr && PADDR_I == `RSP_OFF_PARAM) begin
        param_reg <= PWDATA_I[7:0];
      end
      // a byte written while one is pending is dropped, not queued
      if (apb_wr && PADDR_I == `RSP_OFF_TXDATA && !txpend_reg) begin
        txhold_reg <= PWDATA_I[7:0];
        txpend_reg <= 1'b1;
      end else if (tx_state_reg == ST_IDLE && tick && txpend_reg && (talker_reg || master_reg)) begin
        txpend_reg <= 1'b0;
      end
    end
  end

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else if (apb_setup) begin
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
      if (PADDR_I == `RSP_OFF_STATUS) begin
        PRDATA_O[`RSP_ST_REMOTE]    <= remote_reg; // [RQ14]
        PRDATA_O[`RSP_ST_COMMANDED] <= commanded_reg;
        PRDATA_O[`RSP_ST_TALKER]    <= talker_reg;
        PRDATA_O[`RSP_ST_RXVALID]   <= fifo_out_valid;
        PRDATA_O[`RSP_ST_TXPEND]    <= txpend_reg;
        PRDATA_O[`RSP_ST_MASTER]    <= master_reg;
        PRDATA_O[`RSP_ST_PAREN]     <= par_en_reg;
        PRDATA_O[`RSP_ST_PAREVEN]   <= par_even_reg;
        PRDATA_O[`RSP_ST_ADDR_LO+4:`RSP_ST_ADDR_LO] <= addr_reg;
        PRDATA_O[`RSP_ST_RATE_LO+3:`RSP_ST_RATE_LO] <= rate_reg;
        PRDATA_O[`RSP_ST_LISTENER]  <= listener_reg;
      end else if (PADDR_I == `RSP_OFF_FLAGS) begin
        PRDATA_O[2:0] <= flags_reg;
      end else if (PADDR_I == `RSP_OFF_RXDATA) begin
        PRDATA_O[7:0] <= fifo_out_data;
      end else if (PADDR_I == `RSP_OFF_TXDATA) begin
        PRDATA_O[7:0] <= txhold_reg;
      end else if (PADDR_I == `RSP_OFF_PARAM) begin
        PRDATA_O[7:0] <= param_reg;
      end else begin
        PSLVERR_O <= 1'b1;
      end
    end
  end

endmodule

// >>> tb/rsp_top_props.sv
// rsp_top_props.sv: concurrent checks on the top's ports.
// assumes one clock domain and switch banks held stable outside reset.
`timescale 1ns/10ps
module rsp_top_props (
  input        CLK_I,
  input        RESET_N_I,
  input        CE_I,
  input        PSEL_I,
  input        PENABLE_I,
  input        PWRITE_I,
  input [7:0]  PADDR_I,
  input [31:0] PRDATA_O,
  input        PSLVERR_O,
  input [3:0]  RATE_SELECT_SWITCHES_I,
  input [7:0]  ADDRESS_OPTION_SWITCHES_I,
  input        REMOTE_BTN_I,
  input        LOCAL_BTN_I,
  input        RXD_I,
  input        RPT_TXD_O,
  input        REMOTE_MODE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers; status data is latched at the setup edge
  wire mapped = PADDR_I inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  wire st_rd  = PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == 8'h00 && CE_I;

  ////////////////////////////////////////////////////////////////////////////
  // downstream line, status fields, mode buttons, error response
  a_repeat_one_clock: assert property ($past(CE_I) |-> RPT_TXD_O == $past(RXD_I))
    else $error("repeater not one clock late");
  a_status_address: assert property (st_rd ##1 PENABLE_I
    |-> PRDATA_O[12:8] == ~ADDRESS_OPTION_SWITCHES_I[4:0])
    else $error("status address wrong");
  a_status_options: assert property (st_rd ##1 PENABLE_I |->
    {PRDATA_O[5], PRDATA_O[6], PRDATA_O[7]} == ~ADDRESS_OPTION_SWITCHES_I[7:5])
    else $error("status options wrong");
  a_status_rate: assert property (st_rd |=> PRDATA_O[19:16] == $past(RATE_SELECT_SWITCHES_I))
    else $error("status rate wrong");
  a_status_mode: assert property (st_rd |=> PRDATA_O[0] == $past(REMOTE_MODE_O))
    else $error("status mode bit wrong");
  a_local_wins: assert property (CE_I && LOCAL_BTN_I |=> !REMOTE_MODE_O)
    else $error("local press kept remote");
  a_remote_press: assert property (CE_I && REMOTE_BTN_I && !LOCAL_BTN_I |=> REMOTE_MODE_O)
    else $error("remote press ignored");
  a_mode_drop_cause: assert property ($fell(REMOTE_MODE_O) |-> $past(LOCAL_BTN_I))
    else $error("remote left without local press");
  a_unmapped_error: assert property (PSEL_I && PENABLE_I && $past(CE_I)
    |-> PSLVERR_O == !mapped && (mapped || PWRITE_I || PRDATA_O == 32'h0))
    else $error("error response wrong");
endmodule

bind rsp_top rsp_top_props u_rsp_top_props (
  .CLK_I, .RESET_N_I, .CE_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O, .PSLVERR_O,
  .RATE_SELECT_SWITCHES_I, .ADDRESS_OPTION_SWITCHES_I, .REMOTE_BTN_I, .LOCAL_BTN_I, .RXD_I,
  .RPT_TXD_O, .REMOTE_MODE_O
);

// >>> tb/rsp_remote_ctl.sv
// rsp_remote_ctl.sv: remote controller model on the serial line.
// assumes calls start on a clock edge; a bit cell is BIT clocks.
`timescale 1ns/10ps
module rsp_remote_ctl #(
  parameter int BIT = 64
) (
  input  logic clk_i,
  output logic rxd_o,
  input  logic txd_i
);
  // line idles high between characters
  initial rxd_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // one bit cell, changed just after the edge
  task automatic put(input logic v);
    rxd_o <= v;
    repeat (BIT) @(posedge clk_i);
  endtask

  // start, data lsb first, optional parity, one stop, idle gap
  task automatic send(input logic [7:0] b, input logic pe, ev, bad);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(b[i]);
    if (pe) put((ev ? ^b : ~^b) ^ bad);
    put(1'b1);
    repeat (2 * BIT) @(posedge clk_i);
  endtask

  // samples mid-cell; ok drops on a bad start, parity or stop
  task automatic recv(input logic pe, ev, output logic [7:0] b, output logic ok);
    for (int n = 0; txd_i !== 1'b0 && n < 20000; n++) @(posedge clk_i);
    repeat (BIT / 2) @(posedge clk_i);
    ok = (txd_i === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      b[i] = txd_i;
    end
    if (pe) begin
      repeat (BIT) @(posedge clk_i);
      ok &= (txd_i === (ev ? ^b : ~^b));
    end
    repeat (BIT) @(posedge clk_i);
    ok &= (txd_i === 1'b1);
  endtask
endmodule

// >>> tb/rsp_top_tb.sv
// rsp_top_tb.sv: self-checking bench for the remote serial port top.
// assumes the controller model on the line and a 100 MHz clock.
`timescale 1ns/10ps
module rsp_top_tb;
  localparam int CLK_HZ = 1228800; // 4 clocks a tick at 19200 baud
  logic        CLK_I = 0, RESET_N_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
  logic        REMOTE_BTN_I = 0, LOCAL_BTN_I = 0, CE_I = 1, e_v, pe, ev;
  logic [7:0]  PADDR_I = 0, ADDRESS_OPTION_SWITCHES_I = 8'hFF;
  logic [31:0] PWDATA_I = 0, rd_v;
  logic [3:0]  RATE_SELECT_SWITCHES_I = 4'hF;
  wire  [31:0] PRDATA_O;
  wire         PREADY_O, PSLVERR_O, RXD_I, RPT_TXD_O, TXD_O, REMOTE_MODE_O;
  int          err_total = 0, n_checks = 0;
  logic [7:0]  q[$];

  always #5 CLK_I = ~CLK_I;

  rsp_top #(.CLK_HZ(CLK_HZ), .DEPTH(16)) u_rsp_top (
    .CLK_I, .RESET_N_I, .CE_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
    .PRDATA_O, .PREADY_O, .PSLVERR_O, .RATE_SELECT_SWITCHES_I, .ADDRESS_OPTION_SWITCHES_I,
    .REMOTE_BTN_I, .LOCAL_BTN_I, .RXD_I, .RPT_TXD_O, .TXD_O, .REMOTE_MODE_O);
  rsp_remote_ctl #(.BIT(64)) u_rsp_remote_ctl (.clk_i(CLK_I), .rxd_o(RXD_I), .txd_i(TXD_O));

  ////////////////////////////////////////////////////////////////////////////
  // verdict, comparison and bus tasks
  task automatic report_and_stop();
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= wd;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge CLK_I);
    while (PREADY_O !== 1'b1 && ++n < 50);
    if (n >= 50) err_total++;
    rd_v = PRDATA_O;
    e_v = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge CLK_I);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, x);
    apb(1'b0, a, 32'h0);
    chk(nm, x & m, rd_v & m);
    chk("slverr", {31'd0, a > 8'h10}, {31'd0, e_v});
  endtask

  // one controller character with this phase's parity
  task automatic tx(input logic [7:0] b, input logic bad = 1'b0);
    u_rsp_remote_ctl.send(b, pe, ev, bad);
  endtask

  // option pins read low when closed
  task automatic do_reset(input logic [7:0] opt);
    RESET_N_I <= 1'b0;
    ADDRESS_OPTION_SWITCHES_I <= ~opt;
    repeat (3) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    @(posedge CLK_I);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // slave phases without and with parity, then a master phase
  initial begin
    logic       ok;
    logic [4:0] ad;
    logic [7:0] b, t;
    void'($urandom(64428));
    for (int p = 0; p < 2; p++) begin
      ad = 5'($urandom);
      pe = p[0];
      ev = 1'($urandom);
      do_reset({1'b0, pe, ev, ad});
      rdc("status", 8'h00, 32'hFFFF_FFFF, {12'd0, 4'hF, 3'd0, ad, ev, pe, 6'd0});
      if (p == 0) rdc("unmapped", 8'h14, 32'hFFFF_FFFF, 32'h0);
      tx({3'b100, ad});
      repeat (p ? 1 : 17) begin
        b = 8'($urandom % 124);
        tx(b);
        if (q.size() < 16) q.push_back(b);
      end
      for (int c = 0; c < 2; c++) tx(c ? 8'h7D : 8'h7E);
      if (pe) tx(8'h22, 1'b1);
      tx({3'b100, ad ^ 5'd1});
      tx(8'h33);
      rdc("status", 8'h00, 32'h9, 32'h9);
      rdc("flags", 8'h04, 32'h7, {29'd0, p == 0, 1'b0, pe});
      apb(1'b1, 8'h04, 32'h7);
      rdc("flags", 8'h04, 32'h7, 32'h0);
      while (q.size() > 0) rdc("rxdata", 8'h08, 32'hFF, {24'd0, q.pop_front()});
      rdc("status", 8'h00, 32'h8, 32'h0);
      LOCAL_BTN_I <= 1'b1;
      @(posedge CLK_I);
      LOCAL_BTN_I <= 1'b0;
      // a remote press while frozen must not count
      CE_I <= 1'b0;
      REMOTE_BTN_I <= 1'b1;
      @(posedge CLK_I);
      CE_I <= 1'b1;
      REMOTE_BTN_I <= 1'b0;
      rdc("status", 8'h00, 32'h1, 32'h0);
      tx({3'b110, ad});
      t = 8'($urandom);
      fork
        u_rsp_remote_ctl.recv(pe, ev, b, ok);
        apb(1'b1, 8'h0C, {24'd0, t});
      join
      chk("tx byte", {24'd0, t}, {24'd0, b});
      chk("tx frame", 32'h1, {31'd0, ok});
      REMOTE_BTN_I <= 1'b1;
      @(posedge CLK_I);
      REMOTE_BTN_I <= 1'b0;
      rdc("status", 8'h00, 32'h1, 32'h1);
    end
    do_reset(8'h80);
    t = 8'($urandom);
    fork
      repeat (3) u_rsp_remote_ctl.recv(1'b0, 1'b0, b, ok);
      begin
        rdc("param", 8'h10, 32'hFF, 32'h0);
        apb(1'b1, 8'h10, {24'd0, t});
        rdc("status", 8'h00, 32'h20, 32'h20);
      end
    join
    chk("master byte", {24'd0, t}, {24'd0, b});
    report_and_stop();
  end

  // watchdog at twice the expected run
  initial begin
    repeat (60000) @(posedge CLK_I);
    err_total++;
    report_and_stop();
  end
endmodule
